// ===== rtl/udc_counter.sv
// Overview of operation
// - preset_load high and clear low loads preset value, ignoring clock, direction, enable
// - preset loading is asynchronous: outputs follow preset value immediately
// - counts up when direction high, down when low, if enabled
// - count steps only on rising clock edge, all four bits together
// - chain enable high with load and clear low holds the count
// - clear high forces all four count outputs low, highest priority, regardless of everything
// - counting up, terminal count low only at all ones with chain enable low
// - counting down, terminal count low only at all zeros with chain enable low
`default_nettype none

module udc_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // counter pins
    input wire logic preset_load,
    input wire logic [3:0] preset_value,
    input wire logic count_up,
    input wire logic chain_en_n,
    input wire logic clear,
    output logic [3:0] count_out,
    output logic terminal_count_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o
);

    logic [3:0] count_ff;
    logic [4:0] ctrl_ff;
    logic [3:0] preset_ff;
    logic [31:0] dat_o_ff;

    udc_pkg::udc_reg_type reg_sel;
    logic wr_commit;
    logic rd_capture;

    udc_wb_slave u_slave (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_ack_o(wb_ack_o),
        .reg_sel(reg_sel),
        .wr_commit(wr_commit),
        .rd_capture(rd_capture)
    );

    // control source: pins, or software when the source bit is set
    udc_pkg::udc_ctrl_type pin_ctrl;
    udc_pkg::udc_ctrl_type sw_ctrl;
    udc_pkg::udc_ctrl_type eff;

    assign pin_ctrl = '{load: preset_load, clear: clear, up: count_up,
                        chain_en_n: chain_en_n, preset: preset_value};
    assign sw_ctrl = '{load: ctrl_ff[udc_pkg::CTRL_LOAD],
                       clear: ctrl_ff[udc_pkg::CTRL_CLEAR],
                       up: ctrl_ff[udc_pkg::CTRL_UP],
                       chain_en_n: ctrl_ff[udc_pkg::CTRL_HOLD],
                       preset: preset_ff};
    // pin clear and pin preset always win; software fields act only below them
    wire logic sw_mode = ctrl_ff[udc_pkg::CTRL_SRC_SW];
    assign eff = '{load: pin_ctrl.load | (sw_mode & sw_ctrl.load),
                   clear: pin_ctrl.clear | (sw_mode & sw_ctrl.clear & ~pin_ctrl.load),
                   up: sw_mode ? sw_ctrl.up : pin_ctrl.up,
                   chain_en_n: sw_mode ? sw_ctrl.chain_en_n : pin_ctrl.chain_en_n,
                   preset: pin_ctrl.load ? pin_ctrl.preset : sw_ctrl.preset};

    // clear beats preset, preset beats the value offered
    function automatic logic [3:0] apply_override(input udc_pkg::udc_ctrl_type c,
                                                  input logic [3:0] base);
        if (c.clear) begin
            apply_override = udc_pkg::COUNT_ZERO;
        end else if (c.load) begin
            apply_override = c.preset;
        end else begin
            apply_override = base;
        end
    endfunction

    // clear and preset act on the outputs without waiting for an edge
    wire logic [3:0] shown = apply_override(eff, count_ff);
    assign count_out = shown;

    // 4-bit add and subtract wrap on their own
    wire logic [3:0] count_inc = count_ff + udc_pkg::COUNT_STEP;
    wire logic [3:0] count_dec = count_ff - udc_pkg::COUNT_STEP;
    wire logic [3:0] count_step = eff.up ? count_inc : count_dec;

    // capture clear/preset so the value holds after they drop
    wire logic [3:0] count_kept = eff.chain_en_n ? count_ff : count_step;
    wire logic [3:0] nxt_count = apply_override(eff, count_kept);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_ff <= udc_pkg::COUNT_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // terminal count follows the shown value, so it also sees preset and clear
    wire logic at_top = (shown == udc_pkg::COUNT_ONES) & ~eff.chain_en_n;
    wire logic at_bottom = (shown == udc_pkg::COUNT_ZERO) & ~eff.chain_en_n;
    // this output drives the next stage's chain enable when cascaded
    assign terminal_count_n = eff.up ? ~at_top : ~at_bottom;

    // register writes, low byte lane only carries fields
    wire logic wr_lane0 = wr_commit & wb_sel_i[0];
    wire logic wr_ctrl = wr_lane0 & (reg_sel == udc_pkg::UDC_REG_CTRL);
    wire logic wr_preset = wr_lane0 & (reg_sel == udc_pkg::UDC_REG_PRESET);
    wire logic [4:0] nxt_ctrl = wr_ctrl ? wb_dat_i[4:0] : ctrl_ff;
    wire logic [3:0] nxt_preset = wr_preset ? wb_dat_i[3:0] : preset_ff;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_ff <= udc_pkg::CTRL_RST;
            preset_ff <= udc_pkg::PRESET_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
            preset_ff <= nxt_preset;
        end
    end

    // read mux; unmapped offsets read zero
    wire logic [31:0] status_word = {25'h000_0000,
                                     ctrl_ff[udc_pkg::CTRL_SRC_SW],
                                     eff.up,
                                     terminal_count_n,
                                     shown};
    wire logic [31:0] ctrl_word = {27'h000_0000, ctrl_ff};
    wire logic [31:0] preset_word = {28'h000_0000, preset_ff};
    logic [31:0] rd_word;

    always_comb begin
        case (reg_sel)
            udc_pkg::UDC_REG_CTRL: rd_word = ctrl_word;
            udc_pkg::UDC_REG_PRESET: rd_word = preset_word;
            udc_pkg::UDC_REG_STATUS: rd_word = status_word;
            default: rd_word = udc_pkg::DATA_ZERO;
        endcase
    end

    wire logic [31:0] nxt_dat_o = rd_capture ? rd_word : dat_o_ff;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dat_o_ff <= udc_pkg::DATA_ZERO;
        end else begin
            dat_o_ff <= nxt_dat_o;
        end
    end

    assign wb_dat_o = dat_o_ff;

endmodule

`default_nettype wire

// ===== rtl/udc_wb_slave.sv
`default_nettype none

module udc_wb_slave (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // bus request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    // answer and strobes to the register file
    output logic wb_ack_o,
    output udc_pkg::udc_reg_type reg_sel,
    output logic wr_commit,
    output logic rd_capture
);

    function automatic udc_pkg::udc_reg_type decode_reg(input logic [3:0] adr);
        case (adr)
            udc_pkg::ADDR_CTRL: decode_reg = udc_pkg::UDC_REG_CTRL;
            udc_pkg::ADDR_PRESET: decode_reg = udc_pkg::UDC_REG_PRESET;
            udc_pkg::ADDR_STATUS: decode_reg = udc_pkg::UDC_REG_STATUS;
            default: decode_reg = udc_pkg::UDC_REG_NONE;
        endcase
    endfunction

    logic ack_ff;
    wire logic req = wb_cyc_i & wb_stb_i;
    wire logic nxt_ack = req & ~ack_ff;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= nxt_ack;
        end
    end

    assign wb_ack_o = ack_ff;
    assign reg_sel = decode_reg(wb_adr_i);
    // writes land on the edge where the master sees ack
    assign wr_commit = req & wb_we_i & ack_ff;
    // read data is latched one edge ahead of ack
    assign rd_capture = req & ~wb_we_i & ~ack_ff;

endmodule

`default_nettype wire

// ===== shared/udc_pkg.sv
`default_nettype none

package udc_pkg;

    // counter geometry
    localparam int CNT_W = 4;
    localparam logic [3:0] COUNT_RST = 4'h0;
    localparam logic [3:0] COUNT_ZERO = 4'h0;
    localparam logic [3:0] COUNT_ONES = 4'hF;
    localparam logic [3:0] COUNT_STEP = 4'h1;

    // register byte offsets on the bus
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_PRESET = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // control register fields
    localparam int CTRL_W = 5;
    localparam int CTRL_SRC_SW = 0;
    localparam int CTRL_UP = 1;
    localparam int CTRL_HOLD = 2;
    localparam int CTRL_CLEAR = 3;
    localparam int CTRL_LOAD = 4;
    localparam logic [4:0] CTRL_RST = 5'h02;
    localparam logic [3:0] PRESET_RST = 4'h0;

    // status register fields
    localparam int STATUS_COUNT_LSB = 0;
    localparam int STATUS_TC_N = 4;
    localparam int STATUS_UP = 5;
    localparam int STATUS_SRC_SW = 6;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // one set of counter controls, from the pins or from software
    typedef struct packed {
        logic load;
        logic clear;
        logic up;
        logic chain_en_n;
        logic [3:0] preset;
    } udc_ctrl_type;

    typedef enum logic [1:0] {
        UDC_REG_CTRL = 2'b00,
        UDC_REG_PRESET = 2'b01,
        UDC_REG_STATUS = 2'b10,
        UDC_REG_NONE = 2'b11
    } udc_reg_type;

endpackage

`default_nettype wire

// ===== test/udc_counter_asserts.sv
`default_nettype none
module udc_counter_asserts (
    // clock
    input wire logic ref_clk,
    input wire logic rst_b,
    // pins
    input wire logic preset_load,
    input wire logic [3:0] preset_value,
    input wire logic count_up,
    input wire logic chain_en_n,
    input wire logic clear,
    input wire logic [3:0] count_out,
    input wire logic terminal_count_n,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    wire logic run = !clear && !preset_load;
    logic sw_mode_ff;
    wire logic sw_write = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_adr_i == 4'h0
        && wb_sel_i[0];
    // software control replaces the pin direction and enable, so the hold, count and terminal count checks pause while it is on
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_mode_ff <= 1'b0;
        end else if (sw_write) begin
            sw_mode_ff <= wb_dat_i[0];
        end
    end
    wire logic pins = !sw_mode_ff;
    wire logic run_pins = run && pins;
    AST_CLR: assert property (clear |-> count_out == 4'h0) else $error("clear");
    AST_LOAD: assert property (!clear && preset_load |-> count_out == preset_value)
        else $error("load");
    AST_HOLD: assert property (run_pins && chain_en_n ##1 run_pins |-> $stable(count_out))
        else $error("hold");
    AST_UP: assert property (run_pins && !chain_en_n && count_up ##1 run_pins
        |-> count_out == $past(count_out) + 4'h1) else $error("up");
    AST_DN: assert property (run_pins && !chain_en_n && !count_up ##1 run_pins
        |-> count_out == $past(count_out) - 4'h1) else $error("down");
    AST_TC_UP: assert property (pins && count_up
        |-> terminal_count_n == !(count_out == 4'hF && !chain_en_n)) else $error("tc up");
    AST_TC_DN: assert property (pins && !count_up
        |-> terminal_count_n == !(count_out == 4'h0 && !chain_en_n)) else $error("tc dn");
    AST_ACK: assert property ($rose(wb_cyc_i && wb_stb_i)
        |-> !wb_ack_o ##1 wb_ack_o ##1 !wb_ack_o) else $error("ack");
    AST_ACK_REQ: assert property (wb_ack_o |-> wb_stb_i && $past(wb_stb_i))
        else $error("stray ack");
endmodule
bind udc_counter udc_counter_asserts i_udc_counter_asserts (.ref_clk(ref_clk), .rst_b(rst_b),
    .preset_load(preset_load), .preset_value(preset_value), .count_up(count_up),
    .chain_en_n(chain_en_n), .clear(clear), .count_out(count_out),
    .terminal_count_n(terminal_count_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o));
`default_nettype wire

// ===== test/udc_counter_tb.sv
`default_nettype none
module udc_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, rst_b = 1'b0, preset_load = 1'b0, count_up = 1'b1, clear = 1'b0;
    logic chain_en_n = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic terminal_count_n;
    logic [3:0] preset_value = 4'h0, wb_adr_i = 4'h0, count_out, nxt_cnt;
    logic [3:0] wb_sel_i = 4'h0, bus_sel = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    int n_fail = 0, checks = 0, exp_cnt = 0, i;
    initial forever #10 ref_clk = ~ref_clk;
    udc_counter i_udc_counter (.ref_clk(ref_clk), .rst_b(rst_b), .preset_load(preset_load),
        .preset_value(preset_value), .count_up(count_up), .chain_en_n(chain_en_n),
        .clear(clear), .count_out(count_out), .terminal_count_n(terminal_count_n),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
    udc_next_stage i_udc_next_stage (.ref_clk(ref_clk), .rst_b(rst_b), .clear(clear),
        .count_up(count_up), .chain_en_n(terminal_count_n), .cnt(nxt_cnt));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // one classic cycle, entered right after a rising edge
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, e);
        int k;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_sel_i <= bus_sel;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        if (wb_ack_o !== 1'b1) begin
            n_fail++;
            end_sim();
        end
        if (!w) chk(wb_dat_o, e);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_sel_i <= 4'h0;
        @(posedge ref_clk);
    endtask
    // reset in mid-run: both stages' counts clear, the control register reads back its reset value
    task automatic midrun_reset;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        clear <= 1'b0;
        preset_load <= 1'b0;
        chain_en_n <= 1'b1;
        @(negedge ref_clk);
        chk(32'({nxt_cnt, count_out}), 32'h0000_0000);
        @(posedge ref_clk);
        rst_b <= 1'b1;
        exp_cnt = 0;
        bus(4'h0, 1'b0, 32'h0000_0000, 32'h0000_0002);
    endtask
    task automatic step(input logic cl, ld, up, hold, input logic [3:0] pv);
        logic [3:0] e;
        @(posedge ref_clk);
        if (clear) exp_cnt = 0;
        else if (preset_load) exp_cnt = preset_value;
        else if (!chain_en_n) exp_cnt = count_up ? (exp_cnt + 1) % 16 : (exp_cnt + 15) % 16;
        clear <= cl;
        preset_load <= ld;
        count_up <= up;
        chain_en_n <= hold;
        preset_value <= pv;
        @(negedge ref_clk);
        e = cl ? 4'h0 : ld ? pv : 4'(exp_cnt);
        chk(32'(count_out), 32'(e));
        chk(32'(terminal_count_n),
            32'(!((up ? e == 4'hF : e == 4'h0) && !hold)));
    endtask
    initial begin
        i = $urandom(30337);
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        step(1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
        repeat (20) step(1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
        chk(32'({nxt_cnt, count_out}), 32'h0000_0013);
        repeat (22) step(1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
        chk(32'({nxt_cnt, count_out}), 32'h0000_00FF);
        step(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
        @(posedge ref_clk);
        bus(4'h0, 1'b0, 32'h0000_0000, 32'h0000_0002);
        bus(4'h4, 1'b0, 32'h0000_0000, 32'h0000_0000);
        bus(4'h4, 1'b1, 32'h0000_0009, 32'h0000_0000);
        bus(4'h4, 1'b0, 32'h0000_0000, 32'h0000_0009);
        // a write without the low byte lane is ignored
        bus_sel = 4'hE;
        bus(4'h4, 1'b1, 32'h0000_0005, 32'h0000_0000);
        bus_sel = 4'hF;
        bus(4'h4, 1'b0, 32'h0000_0000, 32'h0000_0009);
        bus(4'hC, 1'b1, 32'hFFFF_FFFF, 32'h0000_0000);
        bus(4'hC, 1'b0, 32'h0000_0000, 32'h0000_0000);
        bus(4'h8, 1'b0, 32'h0000_0000, 32'h0000_0030 | 32'(exp_cnt));
        // software control: count up while the pins hold, then clear and hand back
        bus(4'h0, 1'b1, 32'h0000_0003, 32'h0000_0000);
        bus(4'h8, 1'b0, 32'h0000_0000, 32'h0000_006F);
        bus(4'h0, 1'b1, 32'h0000_0009, 32'h0000_0000);
        bus(4'h0, 1'b1, 32'h0000_0002, 32'h0000_0000);
        bus(4'h8, 1'b0, 32'h0000_0000, 32'h0000_0030);
        exp_cnt = 0;
        for (i = 0; i < 3000; i++) begin
            if (i == 1500) begin
                midrun_reset();
            end
            step($urandom % 16 == 0, $urandom % 8 == 0, 1'($urandom), $urandom % 4 == 0,
                4'($urandom));
        end
        end_sim();
    end
endmodule
`default_nettype wire

// ===== test/udc_next_stage.sv
`default_nettype none
module udc_next_stage (
    // clock
    input wire logic ref_clk,
    input wire logic rst_b,
    // controls
    input wire logic clear,
    input wire logic count_up,
    input wire logic chain_en_n,
    // count
    output logic [3:0] cnt
);
    timeunit 1ns;
    timeprecision 1ns;
    // chained on the first stage's terminal count, same clock
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b || clear)
            cnt <= 4'h0;
        else if (!chain_en_n)
            cnt <= count_up ? cnt + 4'h1 : cnt - 4'h1;
    end
endmodule
`default_nettype wire
